// ---- rtl/itc_consts.vh ----
// constants for the interrupt controller and its 16-bit timer
`ifndef ITC_CONSTS_VH
`define ITC_CONSTS_VH
`define ITC_ADDR_W        8
`define ITC_OFS_TIMER16_MODE 8'h18
`define ITC_OFS_IRQ_FLAG  8'h00
`define ITC_OFS_IRQ_EN    8'h04
`define ITC_OFS_EDGE_SEL  8'h08
`define ITC_OFS_GLOBAL    8'h0c
`define ITC_OFS_SP        8'h10
`define ITC_OFS_COUNT     8'h14
`define ITC_TM_CLK_HI     7
`define ITC_TM_CLK_LO     5
`define ITC_TM_PRE_HI     4
`define ITC_TM_PRE_LO     3
`define ITC_TM_BIT_HI     2
`define ITC_TM_BIT_LO     0
`define ITC_CLK_STOP      3'h0
`define ITC_CLK_SYS       3'h1
`define ITC_CLK_PA4       3'h3
`define ITC_CLK_FAST      3'h4
`define ITC_CLK_SLOW      3'h6
`define ITC_CLK_PA0       3'h7
`define ITC_FLAG_TIMER16  2
`define ITC_EDGE_TIMER16  4
`define ITC_NSRC          6
`define ITC_VECTOR        16'h0010
`define ITC_SP_STEP       8'h02
`define ITC_RESET_BYTE    8'h00
`endif

// ---- rtl/itc_timer16.v ----
// 16-bit up counter with clock select, prescaler and bit-edge request
`timescale 1ns/10ps
`include "itc_consts.vh"
module itc_timer16
(
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [7:0]  mode,
  input  wire        edge_fall,
  input  wire        tick_fast,
  input  wire        tick_slow,
  input  wire        pin_a0,
  input  wire        pin_a4,
  input  wire        load,
  input  wire [15:0] load_value,
  output reg  [15:0] count,
  output wire        event_pulse
);
  reg  [1:0]  pin_d;
  reg  [5:0]  pre;
  reg         sel_d;
  reg         src_tick;
  reg         pre_done;
  wire [2:0]  clk_code = mode[`ITC_TM_CLK_HI:`ITC_TM_CLK_LO];
  wire [1:0]  pre_code = mode[`ITC_TM_PRE_HI:`ITC_TM_PRE_LO];
  wire [3:0]  bit_idx  = {1'b1, mode[`ITC_TM_BIT_HI:`ITC_TM_BIT_LO]};
  wire        sel_bit  = count[bit_idx];

  // pin sources count on rising edges; unused codes 2 and 5 stop the count
  always @*
  begin
    case (clk_code)
      `ITC_CLK_SYS:  src_tick = 1'b1;
      `ITC_CLK_PA4:  src_tick = pin_a4 & ~pin_d[1];
      `ITC_CLK_FAST: src_tick = tick_fast;
      `ITC_CLK_SLOW: src_tick = tick_slow;
      `ITC_CLK_PA0:  src_tick = pin_a0 & ~pin_d[0];
      default:       src_tick = 1'b0;
    endcase
  end

  always @*
  begin
    case (pre_code)
      2'h0:    pre_done = 1'b1;
      2'h1:    pre_done = (pre[1:0] == 2'h3);
      2'h2:    pre_done = (pre[3:0] == 4'hf);
      default: pre_done = (pre == 6'h3f);
    endcase
  end

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_d <= 2'h0;
      pre   <= 6'h00;
      count <= 16'h0000;
      sel_d <= 1'b0;
    end
    else
    begin
      pin_d <= {pin_a4, pin_a0};
      sel_d <= sel_bit;
      if (load)
        count <= load_value;
      else if (src_tick && pre_done)
        count <= count + 16'h0001;
      if (src_tick)
        pre <= pre_done ? 6'h00 : pre + 6'h01;
    end
  end

  // a load that moves the bit also counts as a transition
  assign event_pulse = edge_fall ? (sel_d & ~sel_bit)
                                 : (~sel_d & sel_bit);
endmodule

// ---- rtl/itc_top.v ----
// interrupt controller with 16-bit timer, wishbone register slave
// Summary of operation
// - mode bits 7..5 pick counter clock: stop, system, a4, fast, slow, a0
// - mode bits 4..3 pick prescale of 1, 4, 16 or 64
// - mode bits 2..0 pick counter bit 8 to 15 for the request
// - counter only counts up, one per prescaled tick
// - store instruction loads counter; read instruction returns count
// - edge-select bit 4 chooses rising or falling timer bit edge
// - timer bit transition sets request flag bit 2
// - six sources: pin, timer16, timer2, timer3, comparator, pwm
// - each source has its own enable bit gating dispatch
// - flags set by hardware only; software clears by writing
// - edge-select picks rising, falling or both for pin, comparator and pwm; timer2 and timer3 take both
// - entry saves pc at stack pointer then adds two
// - entry clears global enable and jumps to vector 0x010
// - flags still set when source enable is zero
// - return subtracts two, restores pc, re-enables global interrupts
// - push/pop store or restore accumulator and flags, moving pointer
// - reading flag register returns all pending flags
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/10ps
`include "itc_consts.vh"
module itc_top
#(
  parameter NSRC = `ITC_NSRC
)
(
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        pin_a0,
  input  wire        pin_a5,
  input  wire        ext_pin_sel,
  input  wire        tick_fast,
  input  wire        tick_slow,
  input  wire        pin_a4,
  input  wire        timer2_irq,
  input  wire        timer3_irq,
  input  wire        comparator_irq,
  input  wire        lowpower_pwm_irq,
  input  wire        irq_take,
  input  wire [15:0] cur_pc,
  input  wire        global_en_instr,
  input  wire        global_dis_instr,
  input  wire        ret_instr,
  input  wire        push_af_instr,
  input  wire        pop_af_instr,
  input  wire [7:0]  accumulator,
  input  wire [7:0]  cpu_flags,
  input  wire        store_counter_instr,
  input  wire        read_counter_instr,
  input  wire [15:0] mem_rdata,
  output reg         mem_we,
  output reg  [7:0]  mem_addr,
  output reg  [15:0] mem_wdata,
  output reg         irq_req,
  output reg         pc_load,
  output reg  [15:0] pc_value,
  output reg  [7:0]  acc_restore,
  output reg  [7:0]  flag_restore,
  output reg         af_restore
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_RET   = 2'h1;
  localparam ST_POP   = 2'h2;
  localparam ST_LOADT = 2'h3;

  reg  [7:0]      timer16_mode;
  reg  [NSRC-1:0] irq_enable_reg;
  reg  [NSRC-1:0] irq_flag;
  reg  [7:0]      edge_sel;
  reg             global_en;
  reg  [7:0]      stack_pointer_reg;
  reg  [1:0]      state;
  reg  [NSRC-1:0] src_d;
  reg  [NSRC-1:0] hw_set;
  reg  [NSRC-1:0] next_flag;
  wire [NSRC-1:0] src_now;
  wire [15:0]     count;
  wire            t16_event;
  wire [NSRC-1:0] armed;
  wire            pend;
  reg  [31:0]     next_dat;
  wire            wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire            wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  wire            flag_wr = wb_wr && (wb_adr_i == `ITC_OFS_IRQ_FLAG);

  itc_timer16 u_timer16
  (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .mode        (timer16_mode),
    .edge_fall   (edge_sel[`ITC_EDGE_TIMER16]),
    .tick_fast   (tick_fast),
    .tick_slow   (tick_slow),
    .pin_a0      (pin_a0),
    .pin_a4      (pin_a4),
    .load        (state == ST_LOADT),
    .load_value  (mem_rdata),
    .count       (count),
    .event_pulse (t16_event)
  );

  // source order: 0 pin, 1 comparator, 2 timer16, 3 pwm, 4 timer2, 5 timer3
  assign src_now = {timer3_irq, timer2_irq, lowpower_pwm_irq, 1'b0,
                    comparator_irq, ext_pin_sel ? pin_a5 : pin_a0};

  // a flag waits here until software enables it; it is never lost
  assign armed = irq_flag & irq_enable_reg;
  assign pend  = |armed;

  // edge_sel[2k+1:2k] per source 0, 1 and 3: 0 both, 1 rise, 2 fall; sources 4 and 5 take both edges
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1)
    begin : g_src
      wire rise = src_now[g] & ~src_d[g];
      wire fall = ~src_now[g] & src_d[g];
      wire [1:0] es = (g < 4) ? edge_sel[(2*(g%4))+1 -: 2] : 2'h0;
      always @*
      begin
        if (g == `ITC_FLAG_TIMER16)
        begin
          hw_set[g] = t16_event;
        end
        else if (es == 2'h1)
        begin
          hw_set[g] = rise;
        end
        else if (es == 2'h2)
        begin
          hw_set[g] = fall;
        end
        else
        begin
          hw_set[g] = rise | fall;
        end
      end
    end
  endgenerate

  always @*
  begin
    next_flag = irq_flag;
    if (flag_wr)
    begin
      next_flag = irq_flag & wb_dat_i[NSRC-1:0];
    end
    next_flag = next_flag | hw_set;
  end

  // unmapped offsets read zero so software can probe safely
  always @*
  begin
    case (wb_adr_i)
      `ITC_OFS_IRQ_FLAG:     next_dat = {26'h0, irq_flag};
      `ITC_OFS_IRQ_EN:       next_dat = {26'h0, irq_enable_reg};
      `ITC_OFS_EDGE_SEL:     next_dat = {24'h0, edge_sel};
      `ITC_OFS_GLOBAL:       next_dat = {31'h0, global_en};
      `ITC_OFS_SP:           next_dat = {24'h0, stack_pointer_reg};
      `ITC_OFS_COUNT:        next_dat = {16'h0, count};
      `ITC_OFS_TIMER16_MODE: next_dat = {24'h0, timer16_mode};
      default:               next_dat = 32'h00000000;
    endcase
  end

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer16_mode      <= `ITC_RESET_BYTE;
      irq_enable_reg    <= {NSRC{1'b0}};
      irq_flag          <= {NSRC{1'b0}};
      edge_sel          <= `ITC_RESET_BYTE;
      global_en         <= 1'b0;
      stack_pointer_reg <= `ITC_RESET_BYTE;
      state             <= ST_IDLE;
      src_d             <= {NSRC{1'b0}};
      wb_ack_o          <= 1'b0;
      wb_dat_o          <= 32'h00000000;
      irq_req           <= 1'b0;
      mem_we            <= 1'b0;
      mem_addr          <= 8'h00;
      mem_wdata         <= 16'h0000;
      pc_load           <= 1'b0;
      pc_value          <= 16'h0000;
      acc_restore       <= 8'h00;
      flag_restore      <= 8'h00;
      af_restore        <= 1'b0;
    end
    else
    begin
      src_d     <= src_now;
      irq_flag  <= next_flag;
      wb_ack_o  <= wb_req;
      mem_we    <= 1'b0;
      pc_load   <= 1'b0;
      af_restore <= 1'b0;
      irq_req   <= global_en && pend
                   && !irq_take;
      if (wb_req)
        wb_dat_o <= next_dat;
      if (wb_wr)
      begin
        case (wb_adr_i)
          `ITC_OFS_IRQ_EN:       irq_enable_reg <= wb_dat_i[NSRC-1:0];
          `ITC_OFS_EDGE_SEL:     edge_sel <= wb_dat_i[7:0];
          `ITC_OFS_SP:           stack_pointer_reg <= wb_dat_i[7:0];
          `ITC_OFS_TIMER16_MODE: timer16_mode <= wb_dat_i[7:0];
          default:               ;
        endcase
      end

      // one instruction at a time; a busy state ignores new strobes
      case (state)
        ST_IDLE:
        begin
          // the instruction strobes are one at a time by the core
          if (irq_take)
          begin
            mem_we    <= 1'b1;
            mem_addr  <= stack_pointer_reg;
            mem_wdata <= cur_pc;
            stack_pointer_reg <= stack_pointer_reg + `ITC_SP_STEP;
            global_en <= 1'b0;
            pc_load   <= 1'b1;
            pc_value  <= `ITC_VECTOR;
          end
          else if (ret_instr || pop_af_instr)
          begin
            // bit 0 stays as software left it; the core keeps it zero
            mem_addr  <= stack_pointer_reg - `ITC_SP_STEP;
            stack_pointer_reg <= stack_pointer_reg - `ITC_SP_STEP;
            state     <= ret_instr ? ST_RET : ST_POP;
          end
          else if (push_af_instr)
          begin
            mem_we    <= 1'b1;
            mem_addr  <= stack_pointer_reg;
            mem_wdata <= {cpu_flags, accumulator};
            stack_pointer_reg <= stack_pointer_reg + `ITC_SP_STEP;
          end
          else if (store_counter_instr)
          begin
            state <= ST_LOADT;
          end
          else if (read_counter_instr)
          begin
            mem_we    <= 1'b1;
            mem_wdata <= count;
          end
          else if (global_en_instr)
          begin
            global_en <= 1'b1;
          end
          else if (global_dis_instr)
          begin
            global_en <= 1'b0;
          end
          else if (wb_wr && wb_adr_i == `ITC_OFS_GLOBAL)
          begin
            global_en <= wb_dat_i[0];
          end
        end
        ST_RET:
        begin
          // return re-enables even if entry found it off; nesting needs it
          pc_load   <= 1'b1;
          pc_value  <= mem_rdata;
          global_en <= 1'b1;
          state     <= ST_IDLE;
        end
        ST_POP:
        begin
          acc_restore  <= mem_rdata[7:0];
          flag_restore <= mem_rdata[15:8];
          af_restore   <= 1'b1;
          state        <= ST_IDLE;
        end
        ST_LOADT:
        begin
          // the counter takes mem_rdata during this cycle
          state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ---- tb/itc_chk_monitor.sv ----
// concurrent checks on the controller's core side
`timescale 1ns/10ps
`include "itc_consts.vh"
module itc_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        irq_take,
  input wire logic        ret_instr,
  input wire logic        push_af_instr,
  input wire logic        read_counter_instr,
  input wire logic        global_dis_instr,
  input wire logic [15:0] cur_pc,
  input wire logic [7:0]  accumulator,
  input wire logic [7:0]  cpu_flags,
  input wire logic [15:0] mem_rdata,
  input wire logic        mem_we,
  input wire logic [15:0] mem_wdata,
  input wire logic        irq_req,
  input wire logic        pc_load,
  input wire logic [15:0] pc_value
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  save_pc_a:
    assert property (irq_take |=> mem_we && mem_wdata == $past(cur_pc))
    else $error("pc not saved on entry");
  vector_a:
    assert property (irq_take |=> pc_load && pc_value == `ITC_VECTOR)
    else $error("no jump to vector");
  gie_off_a:
    assert property (irq_take |-> ##2 !irq_req)
    else $error("request stays after entry");
  ret_pc_a:
    assert property (ret_instr |->
      ##2 (pc_load && pc_value == $past(mem_rdata)))
    else $error("pc not restored");
  push_af_a:
    assert property (push_af_instr |=>
      mem_we && mem_wdata == {$past(cpu_flags), $past(accumulator)})
    else $error("push data wrong");
  rd_cnt_a:
    assert property (read_counter_instr |=> mem_we)
    else $error("count not written");
  gie_dis_a:
    assert property (global_dis_instr |-> ##2 !irq_req)
    else $error("request after global disable");
  mem_src_a:
    assert property (mem_we |->
      $past(irq_take || push_af_instr || read_counter_instr))
    else $error("stray memory write");
  entry_c: cover property (irq_take ##1 pc_load);
  ret_c: cover property (ret_instr ##2 pc_load);
  push_c: cover property (push_af_instr ##1 mem_we);
endmodule
bind itc_top itc_chk chk_i (.*);

// ---- tb/itc_mem.sv ----
// data memory model for the core side of the stack
`timescale 1ns/10ps
module itc_mem (
  input  wire logic        clk_sys,
  input  wire logic        mem_we,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] m [256];
  // unwritten words hold a pattern, so a stale read cannot pass
  initial foreach (m[i]) m[i] = 16'hc3a5 ^ 16'(i);
  assign mem_rdata = m[mem_addr];
  always @(posedge clk_sys)
  begin
    if (mem_we)
      m[mem_addr] <= mem_wdata;
  end
endmodule

// ---- tb/tb.sv ----
// bench: registers, timer clocks, flags, entry and return
`timescale 1ns/10ps
`include "itc_consts.vh"
module tb;
  localparam int TAKE = 0, RET = 1, POP = 2, PUSH = 3;
  localparam int STO = 4, RDC = 5, GEN = 6, GDIS = 7;
  logic        clk_sys = 0, rstn = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 0, accumulator = 0, cpu_flags = 0, iv = 0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, d;
  logic [15:0] cur_pc = 0, pcs, afs, c0;
  logic [5:0]  pv = 0;
  logic        ext_pin_sel = 0, timer3_irq = 0;
  logic        comparator_irq = 0, lowpower_pwm_irq = 0;
  wire         irq_take = iv[0], ret_instr = iv[1], pop_af_instr = iv[2];
  wire         push_af_instr = iv[3], store_counter_instr = iv[4];
  wire         read_counter_instr = iv[5], global_en_instr = iv[6];
  wire         global_dis_instr = iv[7];
  wire         pin_a0 = pv[0], pin_a4 = pv[1], pin_a5 = pv[2];
  wire         tick_fast = pv[3], tick_slow = pv[4], timer2_irq = pv[5];
  wire [31:0]  wb_dat_o;
  wire [15:0]  mem_rdata, mem_wdata, pc_value;
  wire [7:0]   mem_addr, acc_restore, flag_restore;
  wire         wb_ack_o, mem_we, irq_req, pc_load, af_restore;
  int          error_cnt = 0, n_tests = 0, e, dl;
  time         t;
  logic [7:0]  ofs [8] = '{`ITC_OFS_IRQ_FLAG, `ITC_OFS_IRQ_EN,
    `ITC_OFS_EDGE_SEL, `ITC_OFS_GLOBAL, `ITC_OFS_SP, `ITC_OFS_COUNT,
    `ITC_OFS_TIMER16_MODE, 8'h40};
  logic [2:0]  cs [5] = '{`ITC_CLK_STOP, `ITC_CLK_PA4, `ITC_CLK_FAST,
    `ITC_CLK_SLOW, `ITC_CLK_PA0};
  always #2 clk_sys = ~clk_sys;
  itc_top dut (.*);
  itc_mem mem_i (.*);
  always @(posedge clk_sys)
  begin
    if (pc_load)
      pcs <= pc_value;
    if (af_restore)
      afs <= {flag_restore, acc_restore};
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    n_tests++;
    if (s !== x)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_sys);
  endtask
  // extra cycles let a two-cycle return finish before the next request
  task op(input int i);
    iv[i] <= 1;
    @(posedge clk_sys);
    iv[i] <= 0;
    repeat (4) @(posedge clk_sys);
  endtask
  task chkq(input string n, input logic x);
    @(negedge clk_sys);
    chk(n, x, irq_req);
    @(posedge clk_sys);
  endtask
  task pulse(input int n);
    repeat (n)
    begin
      pv <= 6'h3f;
      @(posedge clk_sys);
      pv <= 6'h00;
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1;
    @(posedge clk_sys);
    wb(1, 8'h40, 32'hff);
    wb(1, `ITC_OFS_COUNT, 32'hff);
    foreach (ofs[i])
    begin
      wb(0, ofs[i], 0);
      chk("reset", 0, d);
    end
    wb(1, `ITC_OFS_TIMER16_MODE, 32'hff);
    wb(0, `ITC_OFS_TIMER16_MODE, 0);
    chk("mode", 32'hff, d);
    wb(1, `ITC_OFS_TIMER16_MODE, 0);
    $display("registers done");
    wb(1, `ITC_OFS_SP, 32'h20);
    cur_pc <= 16'h1234;
    op(TAKE);
    chk("vector", `ITC_VECTOR, pcs);
    wb(0, `ITC_OFS_GLOBAL, 0);
    chk("gie", 0, d);
    wb(0, `ITC_OFS_SP, 0);
    chk("sp", 32'h22, d);
    op(RET);
    chk("ret pc", 16'h1234, pcs);
    wb(0, `ITC_OFS_SP, 0);
    chk("sp", 32'h20, d);
    wb(0, `ITC_OFS_GLOBAL, 0);
    chk("gie", 1, d);
    op(STO);
    wb(0, `ITC_OFS_COUNT, 0);
    chk("count", 16'h1234, d);
    mem_i.m[8'h20] = 16'h0000;
    op(RDC);
    chk("saved", 16'h1234, mem_i.m[8'h20]);
    accumulator <= 8'h5a;
    cpu_flags <= 8'hc3;
    op(PUSH);
    op(POP);
    chk("af", 16'hc35a, afs);
    $display("entry done");
    foreach (cs[i])
    begin
      wb(1, `ITC_OFS_TIMER16_MODE, {cs[i], 5'h00});
      wb(0, `ITC_OFS_COUNT, 0);
      c0 = d[15:0];
      pulse(8);
      wb(0, `ITC_OFS_COUNT, 0);
      chk("clk", (i == 0) ? 0 : 8, 16'(d[15:0] - c0));
    end
    for (int p = 0; p < 4; p++)
    begin
      wb(1, `ITC_OFS_TIMER16_MODE, {`ITC_CLK_SYS, p[1:0], 3'h0});
      wb(0, `ITC_OFS_COUNT, 0);
      c0 = d[15:0];
      t = $time;
      repeat (128) @(posedge clk_sys);
      wb(0, `ITC_OFS_COUNT, 0);
      e = int'(($time - t) / 4) >> (2 * p);
      dl = int'(16'(d[15:0] - c0));
      chk("prescale", 1, dl >= e - 1 && dl <= e + 1);
    end
    $display("timer done");
    for (int i = 0; i < 2; i++)
    begin
      wb(1, `ITC_OFS_TIMER16_MODE, 0);
      wb(1, `ITC_OFS_EDGE_SEL, 32'(i << 4));
      cur_pc <= (i == 0) ? 16'h00fc : 16'h01fc;
      op(TAKE);
      op(STO);
      wb(1, `ITC_OFS_IRQ_FLAG, 0);
      wb(1, `ITC_OFS_IRQ_EN, 0);
      wb(1, `ITC_OFS_TIMER16_MODE, 32'h20);
      repeat (12) @(posedge clk_sys);
      wb(1, `ITC_OFS_TIMER16_MODE, 0);
      wb(0, `ITC_OFS_IRQ_FLAG, 0);
      chk("edge", 1, d[2]);
      op(GEN);
      chkq("gated", 0);
      wb(1, `ITC_OFS_IRQ_EN, 32'h04);
      chkq("dispatch", 1);
      op(GDIS);
      chkq("off", 0);
      wb(1, `ITC_OFS_IRQ_FLAG, 32'h3b);
      wb(0, `ITC_OFS_IRQ_FLAG, 0);
      chk("clear", 0, d[2]);
    end
    wb(1, `ITC_OFS_IRQ_EN, 0);
    wb(1, `ITC_OFS_EDGE_SEL, 32'h01);
    wb(1, `ITC_OFS_IRQ_FLAG, 0);
    pv <= 6'h01;
    repeat (3) @(posedge clk_sys);
    wb(0, `ITC_OFS_IRQ_FLAG, 0);
    chk("rise", 1, d[0]);
    wb(1, `ITC_OFS_IRQ_FLAG, 0);
    pv <= 6'h00;
    repeat (3) @(posedge clk_sys);
    wb(0, `ITC_OFS_IRQ_FLAG, 0);
    chk("no fall", 0, d[0]);
    wb(1, `ITC_OFS_EDGE_SEL, 32'h02);
    pv <= 6'h01;
    repeat (3) @(posedge clk_sys);
    wb(0, `ITC_OFS_IRQ_FLAG, 0);
    chk("no rise", 0, d[0]);
    pv <= 6'h00;
    repeat (3) @(posedge clk_sys);
    wb(0, `ITC_OFS_IRQ_FLAG, 0);
    chk("fall", 1, d[0]);
    $display("flags done");
    wrap_up();
  end
endmodule
